/* core/ris_consts.vh */
`ifndef RIS_CONSTS_VH
`define RIS_CONSTS_VH
// Register byte offsets on the bus.
`define RIS_OFF_SELCFG 8'h00
`define RIS_OFF_LOSCFG 8'h04
`define RIS_OFF_HOCFG 8'h08
`define RIS_OFF_STATUS 8'h0C
`define RIS_OFF_DACIN 8'h10
// Field positions of the select and status configuration register.
`define RIS_F_ONEMUX_HI 22
`define RIS_F_ONEMUX_LO 20
`define RIS_F_ZEROTYPE_HI 18
`define RIS_F_ZEROTYPE_LO 16
`define RIS_F_LLHDIS 15
`define RIS_F_ZEROMUX_HI 14
`define RIS_F_ZEROMUX_LO 12
`define RIS_F_MODE_HI 11
`define RIS_F_MODE_LO 9
`define RIS_F_SELINV 8
`define RIS_F_EN1 6
`define RIS_F_EN0 5
// Field positions of the loss-detect and DAC trip register.
`define RIS_F_TMO_HI 31
`define RIS_F_TMO_LO 30
`define RIS_F_LOSEN 28
`define RIS_F_ONETYPE_HI 26
`define RIS_F_ONETYPE_LO 24
`define RIS_F_BUF1 21
`define RIS_F_BUF0 20
`define RIS_F_HTRIP_HI 19
`define RIS_F_HTRIP_LO 14
`define RIS_F_LTRIP_HI 11
`define RIS_F_LTRIP_LO 6
`define RIS_F_RAILEN 5
// Field of the holdover exit register.
`define RIS_F_HCNT_HI 19
`define RIS_F_HCNT_LO 6
// Reset values.
`define RIS_RST_SELCFG 32'h0000_0000
`define RIS_RST_LOSCFG 32'h0000_0000
`define RIS_RST_HOCFG 32'h0000_0040
// Selection modes.
`define RIS_MODE_MAN0 3'h0
`define RIS_MODE_MAN1 3'h1
`define RIS_MODE_PIN 3'h3
`define RIS_MODE_AUTO 3'h4
`define RIS_MODE_AUTOPIN 3'h6
// Inactivity timeouts in picoseconds, and the clock period.
`define RIS_CLK_PS 5000
`define RIS_TMO0_PS 1200000
`define RIS_TMO1_PS 206000
`define RIS_TMO2_PS 52900
`define RIS_TMO3_PS 23700
// All times round down to whole cycles, at least one.
`define RIS_CYC(ps) (((ps) / `RIS_CLK_PS) < 1 ? 1 : ((ps) / `RIS_CLK_PS))
`endif

/* core/ris_pin_drive.v */
`timescale 1ns/1ps
`include "ris_consts.vh"
module ris_pin_drive (
  input wire clk,
  input wire rst_n,
  input wire [2:0] pinType,
  input wire [2:0] sourceSelect,
  input wire [6:0] sources,
  output reg pinOut,
  output reg pinOe
);
  reg level;
  reg drive;
  always @* begin
    level = 1'b0;
    if (sourceSelect < 3'h7) begin
      level = sources[sourceSelect];
    end
  end
  always @* begin
    case (pinType)
      3'h3: drive = 1'b1;
      3'h4: drive = 1'b1;
      3'h5: drive = level;
      3'h6: drive = ~level;
      default: drive = 1'b0;
    endcase
  end
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pinOut <= 1'b0;
      pinOe <= 1'b0;
    end else begin
      pinOe <= drive;
      pinOut <= (pinType == 3'h4) ? ~level : level;
    end
  end
endmodule

/* core/ris_ref_select.v */
// Decided for this implementation: the register offsets and register access over AHB-Lite.
`timescale 1ns/1ps
`include "ris_consts.vh"
module ris_ref_select #(
  parameter DAC_W = 10,
  parameter HCNT_W = 14
) (
  input wire clk,
  input wire rst_n,
  input wire [31:0] haddr,
  input wire [1:0] htrans,
  input wire hwrite,
  input wire [2:0] hsize,
  input wire [31:0] hwdata,
  input wire hsel,
  input wire hready,
  output reg [31:0] hrdata,
  output reg hreadyout,
  output reg hresp,
  input wire referenceInputZero,
  input wire referenceInputOne,
  input wire firstLoopLockDetect,
  input wire lockPdClock,
  input wire dacLocked,
  input wire [DAC_W-1:0] tuneDacValue,
  input wire readbackData,
  input wire statusZeroIn,
  input wire statusOneIn,
  output wire statusZeroOut,
  output wire statusZeroOe,
  output wire statusOneOut,
  output wire statusOneOe,
  output reg selectedInput,
  output reg holdoverActive,
  output reg switchEvent,
  output reg inputZeroBufferKind,
  output reg inputOneBufferKind,
  output reg [2:0] statusZeroPullMode,
  output reg [2:0] statusOnePullMode
);
  reg [31:0] selCfg;
  reg [31:0] losCfg;
  reg [31:0] hoCfg;
  reg [2:0] s0z, s0o, s1z, s1o, s2z, s2o, s3l, s3p;
  reg [7:0] busAddr;
  reg busWrite;
  reg [10:0] losCnt0, losCnt1;
  reg lossOfSignalFlag0, lossOfSignalFlag1;
  reg lockPdSeen;
  reg [HCNT_W-1:0] exitCnt;
  reg dacHigh, dacLow;
  reg railPrev;
  reg switchReq;
  reg next_sel;

  wire [2:0] mode = selCfg[`RIS_F_MODE_HI:`RIS_F_MODE_LO];
  wire [1:0] tmoSel = losCfg[`RIS_F_TMO_HI:`RIS_F_TMO_LO];
  wire losEnable = losCfg[`RIS_F_LOSEN];
  wire railEnable = losCfg[`RIS_F_RAILEN];
  wire [HCNT_W-1:0] exitTarget = hoCfg[`RIS_F_HCNT_HI:`RIS_F_HCNT_LO];

  function [10:0] tmoCycles;
    input [1:0] code;
    integer cyc;
    begin
      case (code)
        2'h0: cyc = `RIS_CYC(`RIS_TMO0_PS);
        2'h1: cyc = `RIS_CYC(`RIS_TMO1_PS);
        2'h2: cyc = `RIS_CYC(`RIS_TMO2_PS);
        default: cyc = `RIS_CYC(`RIS_TMO3_PS);
      endcase
      tmoCycles = cyc[10:0];
    end
  endfunction

  function isEdge;
    input [2:0] sync;
    begin
      isEdge = sync[2] ^ sync[1];
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers: three stages, a change counts while stages two and three differ.
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s0z <= 3'h0; s0o <= 3'h0; s1z <= 3'h0; s1o <= 3'h0;
      s2z <= 3'h0; s2o <= 3'h0; s3l <= 3'h0; s3p <= 3'h0;
    end else begin
      s0z <= {s0z[1:0], referenceInputZero};
      s0o <= {s0o[1:0], referenceInputOne};
      s1z <= {s1z[1:0], statusZeroIn};
      s1o <= {s1o[1:0], statusOneIn};
      s2z <= {s2z[1:0], firstLoopLockDetect};
      s2o <= {s2o[1:0], dacLocked};
      s3l <= {s3l[1:0], readbackData};
      s3p <= {s3p[1:0], lockPdClock};
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Bus slave: zero wait states, always OKAY.
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      busAddr <= 8'h00;
      busWrite <= 1'b0;
      hreadyout <= 1'b1;
      hresp <= 1'b0;
      hrdata <= 32'h0000_0000;
      selCfg <= `RIS_RST_SELCFG;
      losCfg <= `RIS_RST_LOSCFG;
      hoCfg <= `RIS_RST_HOCFG;
    end else begin
      busWrite <= hsel && hready && htrans[1] && hwrite;
      if (hsel && hready && htrans[1]) begin
        busAddr <= haddr[7:0];
      end
      if (hsel && hready && htrans[1] && !hwrite) begin
        case (haddr[7:0])
          `RIS_OFF_SELCFG: hrdata <= selCfg;
          `RIS_OFF_LOSCFG: hrdata <= losCfg;
          `RIS_OFF_HOCFG: hrdata <= hoCfg;
          `RIS_OFF_STATUS: hrdata <= {25'h000_0000, dacHigh, dacLow, switchReq,
                                      holdoverActive, selectedInput,
                                      lossOfSignalFlag1, lossOfSignalFlag0};
          `RIS_OFF_DACIN: hrdata <= {{(32-DAC_W){1'b0}}, tuneDacValue};
          default: hrdata <= 32'h0000_0000;
        endcase
      end
      if (busWrite) begin
        case (busAddr)
          `RIS_OFF_SELCFG: selCfg <= hwdata;
          `RIS_OFF_LOSCFG: losCfg <= hwdata;
          `RIS_OFF_HOCFG: hoCfg <= hwdata;
          default: hoCfg <= hoCfg;
        endcase
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Inactivity detection per reference input.
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      losCnt0 <= 11'd0;
      losCnt1 <= 11'd0;
      lossOfSignalFlag0 <= 1'b0;
      lossOfSignalFlag1 <= 1'b0;
    end else if (!losEnable) begin
      losCnt0 <= 11'd0;
      losCnt1 <= 11'd0;
      lossOfSignalFlag0 <= 1'b0;
      lossOfSignalFlag1 <= 1'b0;
    end else begin
      if (isEdge(s0z)) begin
        losCnt0 <= 11'd0;
        lossOfSignalFlag0 <= 1'b0;
      end else if (losCnt0 >= tmoCycles(tmoSel) - 11'd1) begin
        lossOfSignalFlag0 <= 1'b1;
      end else begin
        losCnt0 <= losCnt0 + 11'd1;
      end
      if (isEdge(s0o)) begin
        losCnt1 <= 11'd0;
        lossOfSignalFlag1 <= 1'b0;
      end else if (losCnt1 >= tmoCycles(tmoSel) - 11'd1) begin
        lossOfSignalFlag1 <= 1'b1;
      end else begin
        losCnt1 <= losCnt1 + 11'd1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // DAC rail thresholds: code n trips within (n+1)/64 of the rail.
  wire [DAC_W+5:0] dacScaled = {6'h00, tuneDacValue} << 6;
  wire [DAC_W+5:0] fullScale = {6'h00, {DAC_W{1'b1}}} << 6;
  wire [DAC_W+5:0] hiBand = ({{DAC_W{1'b0}}, losCfg[`RIS_F_HTRIP_HI:`RIS_F_HTRIP_LO]} + 1'b1)
                            * {6'h00, {DAC_W{1'b1}}};
  wire [DAC_W+5:0] loBand = ({{DAC_W{1'b0}}, losCfg[`RIS_F_LTRIP_HI:`RIS_F_LTRIP_LO]} + 1'b1)
                            * {6'h00, {DAC_W{1'b1}}};
  wire railTrip = railEnable && (dacHigh || dacLow);

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      dacHigh <= 1'b0;
      dacLow <= 1'b0;
      railPrev <= 1'b0;
    end else begin
      dacHigh <= (fullScale - dacScaled) <= hiBand;
      dacLow <= dacScaled <= loBand;
      railPrev <= railTrip;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Reference selection, switch events and holdover.
  wire lockFall = s2z[2] && !s2z[1];
  wire lockLossEvent = lockFall && !selCfg[`RIS_F_LLHDIS];
  wire railEvent = railTrip && !railPrev;
  wire autoMode = (mode == `RIS_MODE_AUTO) || (mode == `RIS_MODE_AUTOPIN);
  wire pinZ = (mode == `RIS_MODE_AUTOPIN && selCfg[`RIS_F_SELINV]) ? ~s1z[2] : s1z[2];
  wire pinO = (mode == `RIS_MODE_AUTOPIN && selCfg[`RIS_F_SELINV]) ? ~s1o[2] : s1o[2];
  wire ok0 = selCfg[`RIS_F_EN0] && !lossOfSignalFlag0;
  wire ok1 = selCfg[`RIS_F_EN1] && !lossOfSignalFlag1;
  wire curBad = (selectedInput ? lossOfSignalFlag1 : lossOfSignalFlag0)
                || lockLossEvent || railEvent;

  always @* begin
    next_sel = selectedInput;
    case (mode)
      `RIS_MODE_MAN0: next_sel = 1'b0;
      `RIS_MODE_MAN1: next_sel = 1'b1;
      `RIS_MODE_PIN: next_sel = pinO && !pinZ;
      `RIS_MODE_AUTO: begin
        if (curBad || !(selectedInput ? ok1 : ok0)) begin
          if (ok0 && !(selectedInput == 1'b0 && curBad)) next_sel = 1'b0;
          else if (ok1) next_sel = 1'b1;
        end
      end
      `RIS_MODE_AUTOPIN: begin
        if (curBad || !(selectedInput ? ok1 : ok0)) begin
          next_sel = pinO && !pinZ ? 1'b1 : (pinZ ? 1'b0 : ok0 ? 1'b0 : 1'b1);
        end
      end
      default: next_sel = selectedInput;
    endcase
  end

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      selectedInput <= 1'b0;
      switchEvent <= 1'b0;
      switchReq <= 1'b0;
      holdoverActive <= 1'b0;
      exitCnt <= {HCNT_W{1'b0}};
      lockPdSeen <= 1'b0;
      inputZeroBufferKind <= 1'b0;
      inputOneBufferKind <= 1'b0;
      statusZeroPullMode <= 3'h0;
      statusOnePullMode <= 3'h0;
    end else begin
      selectedInput <= next_sel;
      switchEvent <= autoMode && (lockLossEvent || railEvent);
      switchReq <= lockLossEvent || railEvent;
      inputZeroBufferKind <= losCfg[`RIS_F_BUF0];
      inputOneBufferKind <= losCfg[`RIS_F_BUF1];
      statusZeroPullMode <= selCfg[`RIS_F_ZEROTYPE_HI:`RIS_F_ZEROTYPE_LO];
      statusOnePullMode <= losCfg[`RIS_F_ONETYPE_HI:`RIS_F_ONETYPE_LO];
      lockPdSeen <= s3p[2];
      if (lockLossEvent || railTrip) begin
        holdoverActive <= 1'b1;
        exitCnt <= {HCNT_W{1'b0}};
      end else if (holdoverActive) begin
        if (!s2z[2]) begin
          exitCnt <= {HCNT_W{1'b0}};
        end else if (s3p[2] && !lockPdSeen) begin
          if (exitTarget != {HCNT_W{1'b0}} && exitCnt + 1'b1 >= exitTarget) begin
            holdoverActive <= 1'b0;
          end
          exitCnt <= exitCnt + 1'b1;
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Status pin drivers; source index follows the mux code.
  ris_pin_drive u_pinZero (
    .clk(clk),
    .rst_n(rst_n),
    .pinType(selCfg[`RIS_F_ZEROTYPE_HI:`RIS_F_ZEROTYPE_LO]),
    .sourceSelect(selCfg[`RIS_F_ZEROMUX_HI:`RIS_F_ZEROMUX_LO]),
    .sources({s3l[2], dacHigh, dacLow, s2o[2], ~selectedInput, lossOfSignalFlag0, 1'b0}),
    .pinOut(statusZeroOut),
    .pinOe(statusZeroOe)
  );

  ris_pin_drive u_pinOne (
    .clk(clk),
    .rst_n(rst_n),
    .pinType(losCfg[`RIS_F_ONETYPE_HI:`RIS_F_ONETYPE_LO]),
    .sourceSelect(selCfg[`RIS_F_ONEMUX_HI:`RIS_F_ONEMUX_LO]),
    .sources({s3l[2], dacHigh, dacLow, s2o[2], selectedInput, lossOfSignalFlag1, 1'b0}),
    .pinOut(statusOneOut),
    .pinOe(statusOneOe)
  );
endmodule

/* verification/ris_ref_select_bench.sv */
`timescale 1ns/1ps
`include "ris_consts.vh"
`define CHK(a, e) \
  begin \
    nCompared = nCompared + 1; \
    if ((a) !== (e)) begin \
      nFail = nFail + 1; \
      $display("CHECK FAILED at %0t: got %h, expected %h", $time, (a), (e)); \
    end \
  end
module ris_ref_select_bench;
  reg clk = 1'h0;
  reg rst_n = 1'h0;
  reg [31:0] haddr = 32'h0000_0000;
  reg [1:0] htrans = 2'h0;
  reg hwrite = 1'h0;
  reg [31:0] hwdata = 32'h0000_0000;
  reg firstLoopLockDetect = 1'h1;
  reg dacLocked = 1'h1;
  reg readbackData = 1'h1;
  reg statusZeroIn = 1'h0;
  reg statusOneIn = 1'h0;
  reg run0 = 1'h1;
  reg run1 = 1'h1;
  reg [9:0] tuneDacValue = 10'h200;
  wire referenceInputZero, referenceInputOne, lockPdClock, hreadyout, hresp, statusZeroOut;
  wire statusZeroOe, statusOneOut, statusOneOe, selectedInput, holdoverActive, switchEvent;
  wire inputZeroBufferKind, inputOneBufferKind;
  wire [31:0] hrdata;
  wire [2:0] statusZeroPullMode, statusOnePullMode;
  reg [31:0] rdat;
  reg [3:0] t;
  integer nFail = 0;
  integer nCompared = 0;
  integer cycles = 0;
  integer k;
  // Readback high, DAC locked and input zero selected; the rest low.
  localparam [6:0] MUX_EXP = 7'h4C;
  always #2.5 clk = ~clk;
  ris_ref_source src_u (.run0, .run1, .ref0(referenceInputZero), .ref1(referenceInputOne),
    .pdClk(lockPdClock));
  ris_ref_select dut_u (.clk, .rst_n, .haddr, .htrans, .hwrite, .hsize(3'h2), .hwdata,
    .hsel(1'h1), .hready(hreadyout), .hrdata, .hreadyout, .hresp, .referenceInputZero,
    .referenceInputOne, .firstLoopLockDetect, .lockPdClock, .dacLocked, .tuneDacValue,
    .readbackData, .statusZeroIn, .statusOneIn, .statusZeroOut, .statusZeroOe, .statusOneOut,
    .statusOneOe, .selectedInput, .holdoverActive, .switchEvent, .inputZeroBufferKind,
    .inputOneBufferKind, .statusZeroPullMode, .statusOnePullMode);
  ////////////////////////////////////////
  task reportAndStop;
    $display("Compared %0d, failed %0d", nCompared, nFail);
    if (nFail == 0 && nCompared > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      nFail = nFail + 1;
      reportAndStop;
    end
  end
  task automatic xfer(input [7:0] a, input w, input [31:0] d);
    @(posedge clk);
    haddr <= {24'h00_0000, a};
    hwrite <= w;
    htrans <= 2'h2;
    @(posedge clk);
    while (hreadyout !== 1'h1) @(posedge clk);
    htrans <= 2'h0;
    hwdata <= d;
    @(posedge clk);
    while (hreadyout !== 1'h1) @(posedge clk);
    rdat = hrdata;
  endtask
  task automatic wr(input [7:0] a, input [31:0] d);
    xfer(a, 1'h1, d);
  endtask
  task automatic rd(input [7:0] a);
    xfer(a, 1'h0, 32'h0000_0000);
  endtask
  task automatic idle(input integer n);
    repeat (n) @(posedge clk);
  endtask
  // Counts switch pulses; each is one cycle wide, so every pulse is seen once.
  task automatic countSw(input integer n);
    k = 0;
    repeat (n) begin
      @(posedge clk);
      if (switchEvent === 1'h1) k = k + 1;
    end
  endtask
  ////////////////////////////////////////
  task regTest;
    rd(`RIS_OFF_HOCFG);
    `CHK(rdat, `RIS_RST_HOCFG)
    wr(8'h20, 32'hFFFF_FFFF);
    rd(8'h20);
    `CHK(rdat, 32'h0000_0000)
    wr(`RIS_OFF_LOSCFG, 32'hD020_0000);
    rd(`RIS_OFF_LOSCFG);
    `CHK(rdat, 32'hD020_0000)
    `CHK({inputOneBufferKind, inputZeroBufferKind}, 2'h2)
  endtask
  task pinTest;
    for (t = 0; t < 7; t = t + 1) begin
      wr(`RIS_OFF_SELCFG, {9'h000, 3'h3, 1'h0, t[2:0], 16'h0000});
      wr(`RIS_OFF_LOSCFG, {5'h00, t[2:0], 24'h00_0000});
      idle(2);
      `CHK({statusZeroOe, statusZeroOe & statusZeroOut}, {t == 3 || t == 4 || t == 6, t == 4})
      `CHK({statusOneOe, statusOneOe & statusOneOut}, {t == 3 || t == 4 || t == 5, t == 3 || t == 5})
      `CHK({statusOnePullMode, statusZeroPullMode}, {t[2:0], t[2:0]})
    end
    for (t = 0; t < 7; t = t + 1) begin
      wr(`RIS_OFF_SELCFG, {13'h0000, 3'h3, 1'h0, t[2:0], 12'h000});
      idle(2);
      `CHK(statusZeroOut, MUX_EXP[t])
    end
  endtask
  task lossTest;
    wr(`RIS_OFF_LOSCFG, 32'h9000_0000);
    run0 <= 1'h0;
    idle(4);
    rd(`RIS_OFF_STATUS);
    `CHK(rdat[1:0], 2'h0)
    idle(20);
    rd(`RIS_OFF_STATUS);
    `CHK(rdat[1:0], 2'h1)
    run0 <= 1'h1;
    idle(8);
    rd(`RIS_OFF_STATUS);
    `CHK(rdat[1:0], 2'h0)
    wr(`RIS_OFF_LOSCFG, 32'h8000_0000);
    run1 <= 1'h0;
    idle(30);
    rd(`RIS_OFF_STATUS);
    `CHK(rdat[1:0], 2'h0)
    run1 <= 1'h1;
  endtask
  task selectTest;
    wr(`RIS_OFF_SELCFG, 32'h0000_0200);
    idle(6);
    `CHK(selectedInput, 1'h1)
    statusOneIn <= 1'h1;
    wr(`RIS_OFF_SELCFG, 32'h0000_8600);
    idle(6);
    `CHK(selectedInput, 1'h1)
    statusOneIn <= 1'h0;
    idle(6);
    `CHK(selectedInput, 1'h0)
    statusOneIn <= 1'h1;
    wr(`RIS_OFF_SELCFG, 32'h0000_8700);
    idle(6);
    `CHK(selectedInput, 1'h1)
    // Inverted pins in mode 6: pin zero low reads as asserted, so a lock loss picks input zero.
    wr(`RIS_OFF_SELCFG, 32'h0000_0D60);
    firstLoopLockDetect <= 1'h0;
    idle(6);
    `CHK(selectedInput, 1'h0)
    firstLoopLockDetect <= 1'h1;
  endtask
  task autoTest;
    wr(`RIS_OFF_LOSCFG, 32'h9000_0000);
    wr(`RIS_OFF_SELCFG, 32'h0000_0860);
    idle(6);
    `CHK(selectedInput, 1'h0)
    run0 <= 1'h0;
    countSw(40);
    `CHK({k == 0, selectedInput}, 2'h3)
    run0 <= 1'h1;
    idle(8);
    firstLoopLockDetect <= 1'h0;
    countSw(8);
    `CHK({k != 0, holdoverActive, selectedInput}, 3'h6)
    firstLoopLockDetect <= 1'h1;
    idle(30);
    `CHK(holdoverActive, 1'h0)
    wr(`RIS_OFF_SELCFG, 32'h0000_8860);
    firstLoopLockDetect <= 1'h0;
    countSw(20);
    `CHK({k == 0, holdoverActive}, 2'h2)
    firstLoopLockDetect <= 1'h1;
    // Input one is disabled, so losing input zero must not move the selection.
    wr(`RIS_OFF_SELCFG, 32'h0000_0820);
    run0 <= 1'h0;
    idle(40);
    `CHK(selectedInput, 1'h0)
    run0 <= 1'h1;
    idle(8);
  endtask
  task railTest;
    wr(`RIS_OFF_SELCFG, 32'h0000_0860);
    wr(`RIS_OFF_LOSCFG, 32'h0000_0020);
    tuneDacValue <= 10'h005;
    countSw(8);
    rd(`RIS_OFF_STATUS);
    `CHK({k != 0, holdoverActive, selectedInput, rdat[6:5]}, 5'h1D)
    tuneDacValue <= 10'h3FC;
    idle(6);
    rd(`RIS_OFF_STATUS);
    `CHK({holdoverActive, rdat[6:5]}, 3'h6)
    tuneDacValue <= 10'h200;
    idle(40);
    rd(`RIS_OFF_STATUS);
    `CHK({holdoverActive, rdat[6:5]}, 3'h0)
  endtask
  initial begin
    repeat (6) @(posedge clk);
    rst_n <= 1'h1;
    regTest;
    pinTest;
    lossTest;
    selectTest;
    autoTest;
    railTest;
    reportAndStop;
  end
endmodule

/* verification/ris_ref_select_props.sv */
`timescale 1ns/1ps
module ris_ref_select_props (
  input wire clk,
  input wire rst_n,
  input wire [1:0] htrans,
  input wire hwrite,
  input wire hsel,
  input wire hready,
  input wire [31:0] hrdata,
  input wire hreadyout,
  input wire hresp,
  input wire statusZeroOut,
  input wire statusZeroOe,
  input wire statusOneOe,
  input wire switchEvent,
  input wire [2:0] statusZeroPullMode,
  input wire [2:0] statusOnePullMode
);
  default clocking @(posedge clk);
  endclocking
  default disable iff (!rst_n);
  // A type must hold two cycles; the drive stage and the copied field both follow the register field one cycle later, at the same edge.
  sequence zeroHeld(lo, hi);
    statusZeroPullMode inside {[lo:hi]} && $past(statusZeroPullMode) inside {[lo:hi]};
  endsequence
  sequence oneInput;
    statusOnePullMode < 3 && $past(statusOnePullMode) < 3;
  endsequence
  bus_answer_a: assert property (hreadyout && !hresp)
    else $error("bus answer not ready or not okay");
  read_hold_a: assert property (!(hsel && hready && htrans[1] && !hwrite) |=> $stable(hrdata))
    else $error("read data changed without a read");
  zero_input_a: assert property (zeroHeld(0, 2) |-> !statusZeroOe)
    else $error("status pin zero driven while an input");
  one_input_a: assert property (oneInput |-> !statusOneOe)
    else $error("status pin one driven while an input");
  push_pull_a: assert property (zeroHeld(3, 4) |-> statusZeroOe)
    else $error("push-pull pin not driven");
  open_source_a: assert property (zeroHeld(5, 5) |-> !(statusZeroOe && !statusZeroOut))
    else $error("open source pin drove low");
  open_drain_a: assert property (zeroHeld(6, 6) |-> !(statusZeroOe && statusZeroOut))
    else $error("open drain pin drove high");
  switch_pulse_a: assert property (switchEvent |=> !switchEvent)
    else $error("switch event longer than one cycle");
endmodule
////////////////////////////////////////
bind ris_ref_select ris_ref_select_props chk_u (.clk, .rst_n, .htrans, .hwrite, .hsel, .hready,
  .hrdata, .hreadyout, .hresp, .statusZeroOut, .statusZeroOe, .statusOneOe, .switchEvent,
  .statusZeroPullMode, .statusOnePullMode);

/* verification/ris_ref_source.sv */
`timescale 1ns/1ps
module ris_ref_source (
  input wire run0,
  input wire run1,
  output reg ref0,
  output reg ref1,
  output reg pdClk
);
  // A stopped source parks low, as a dead clock buffer would; rates are unrelated to clk.
  initial begin
    ref0 = 1'h0;
    ref1 = 1'h0;
    pdClk = 1'h0;
  end
  always #7 ref0 = run0 ? ~ref0 : 1'h0;
  always #9 ref1 = run1 ? ~ref1 : 1'h0;
  always #11 pdClk = ~pdClk;
endmodule
